// ===== logic/oamc_top.sv
// oamc_top: register file and switch control for the on-chip amplifier
`timescale 1ns/1ps
module oamc_top #(
   parameter int         N_SRC        = 16,
   parameter logic [7:0] FACTORY_TRIM = oamc_pkg::FACTORY_TRIM_DEFAULT
) (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic [N_SRC-1:0] ovr_src,
   input  wire logic       port_out_drive,
   input  wire logic       port_out_oe,
   output logic            amp_output_pin_o,
   output logic            amp_output_pin_oe,
   input  wire logic       port_inv_drive,
   input  wire logic       port_inv_oe,
   output logic            amp_inv_pin_o,
   output logic            amp_inv_pin_oe,
   output logic            amp_enable,
   output logic            charge_pump_on,
   output logic [1:0]      amp_mode,
   output logic [2:0]      noninv_route,
   output logic [1:0]      amp_noninv_pin,
   output logic [2:0]      inv_route,
   output logic [1:0]      amp_inv_pin,
   output logic            ladder_on,
   output logic [2:0]      ladder_gain,
   output logic [7:0]      offset_trim,
   output logic            adc_from_amp,
   output logic [1:0]      adc_noninv_pin
);
   // ======================================================================================
   // registers
   logic [7:0] con0_reg;
   logic [7:0] con1_reg;
   logic [7:0] con2_reg;
   logic [7:0] con3_reg;
   logic [7:0] hwc_reg;
   logic [7:0] osrc_reg;
   logic [7:0] trim_reg;
   logic [7:0] adc_reg;
   logic [7:0] rdata_next;
   logic       ovr_level;
   logic [2:0] hw_cfg;
   logic [1:0] mode_next;
   logic [1:0] mode_reg;
   logic       unity;
   logic [2:0] nr_next;
   logic [2:0] ir_next;

   wire logic override_enable   = hwc_reg[oamc_pkg::HWC_OVREN];
   wire logic override_polarity = hwc_reg[oamc_pkg::HWC_OVPOL];
   wire logic [2:0] override_high_config = hwc_reg[6:4];
   wire logic [2:0] override_low_config  = hwc_reg[2:0];
   wire logic unity_gain_select = con0_reg[oamc_pkg::CON0_UNITY];
   wire logic [1:0] soc_field = con0_reg[1:0];
   wire logic ladder_enable     = con1_reg[oamc_pkg::CON1_LADEN];
   wire logic [2:0] gain_select = con1_reg[6:4];
   wire logic [2:0] negative_pin_select = con1_reg[2:0];
   wire logic [2:0] inv_channel_select    = con2_reg[6:4];
   wire logic [2:0] noninv_channel_select = con2_reg[2:0];
   wire logic [1:0] positive_pin_select   = con3_reg[1:0];
   wire logic [1:0] adc_positive_channel_select = adc_reg[1:0];
   wire logic adc_mode = adc_reg[oamc_pkg::ADC_OPAMD];

   function automatic logic [2:0] chan_route(input logic [2:0] code);
      case (code)
         oamc_pkg::CH_RAIL:   chan_route = oamc_pkg::SRC_RAIL;
         oamc_pkg::CH_LADDER: chan_route = oamc_pkg::SRC_LADDER;
         oamc_pkg::CH_PIN:    chan_route = oamc_pkg::SRC_PIN;
         oamc_pkg::CH_HALF:   chan_route = oamc_pkg::SRC_HALF;
         oamc_pkg::CH_DAC1:   chan_route = oamc_pkg::SRC_DAC1;
         oamc_pkg::CH_DAC2:   chan_route = oamc_pkg::SRC_DAC2;
         default:             chan_route = oamc_pkg::SRC_NONE;
      endcase
   endfunction

   // ======================================================================================
   // register writes
   // only implemented bits are kept, so unused bits always read back as zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         con0_reg <= oamc_pkg::RST_ZERO;
         con1_reg <= oamc_pkg::RST_ZERO;
         con2_reg <= oamc_pkg::RST_ZERO;
         con3_reg <= oamc_pkg::RST_ZERO;
         hwc_reg  <= oamc_pkg::RST_ZERO;
         osrc_reg <= oamc_pkg::RST_ZERO;
         adc_reg  <= oamc_pkg::RST_ZERO;
      end else if (reg_wr) begin
         if (reg_addr == oamc_pkg::ADDR_CON0) begin
            con0_reg <= reg_wdata & 8'hAB;
         end else if (reg_addr == oamc_pkg::ADDR_CON1) begin
            con1_reg <= reg_wdata & 8'h7F;
         end else if (reg_addr == oamc_pkg::ADDR_CON2) begin
            con2_reg <= reg_wdata & 8'h77;
         end else if (reg_addr == oamc_pkg::ADDR_CON3) begin
            con3_reg <= reg_wdata & 8'h03;
         end else if (reg_addr == oamc_pkg::ADDR_HWC) begin
            hwc_reg <= reg_wdata;
         end else if (reg_addr == oamc_pkg::ADDR_OSRC) begin
            osrc_reg <= reg_wdata & 8'h0F;
         end else if (reg_addr == oamc_pkg::ADDR_ADC) begin
            adc_reg <= reg_wdata & 8'h83;
         end
      end
   end

   // factory value comes back on every reset, whatever software wrote
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         trim_reg <= FACTORY_TRIM;
      end else if (reg_wr && reg_addr == oamc_pkg::ADDR_TRIM) begin
         trim_reg <= reg_wdata;
      end
   end

   // ======================================================================================
   // read port, data one cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_addr == oamc_pkg::ADDR_CON0) begin
         rdata_next = con0_reg;
      end else if (reg_addr == oamc_pkg::ADDR_CON1) begin
         rdata_next = con1_reg;
      end else if (reg_addr == oamc_pkg::ADDR_CON2) begin
         rdata_next = con2_reg;
      end else if (reg_addr == oamc_pkg::ADDR_CON3) begin
         rdata_next = con3_reg;
      end else if (reg_addr == oamc_pkg::ADDR_HWC) begin
         rdata_next = hwc_reg;
      end else if (reg_addr == oamc_pkg::ADDR_OSRC) begin
         rdata_next = osrc_reg;
      end else if (reg_addr == oamc_pkg::ADDR_TRIM) begin
         rdata_next = trim_reg;
      end else if (reg_addr == oamc_pkg::ADDR_ADC) begin
         rdata_next = adc_reg;
      end else if (reg_addr == oamc_pkg::ADDR_STAT) begin
         rdata_next = {5'h00, ovr_level, mode_reg};
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ======================================================================================
   // override path
   oamc_ovr_sync #(
      .N_SRC (N_SRC)
   ) u_sync (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .src_in    (ovr_src),
      .src_sel   (osrc_reg[$clog2(N_SRC)-1:0]),
      .polarity  (override_polarity),
      .ovr_level (ovr_level)
   );

   assign hw_cfg = ovr_level ? override_high_config : override_low_config;

   // ======================================================================================
   // mode selection
   always_comb begin
      mode_next = oamc_pkg::OAMC_MODE_BASIC;
      if (override_enable) begin
         case (hw_cfg)
            oamc_pkg::HW_UNITY: mode_next = oamc_pkg::OAMC_MODE_UNITY;
            oamc_pkg::HW_GND:   mode_next = oamc_pkg::OAMC_MODE_GND;
            oamc_pkg::HW_VDD:   mode_next = oamc_pkg::OAMC_MODE_VDD;
            default:            mode_next = oamc_pkg::OAMC_MODE_BASIC;
         endcase
      end else begin
         case (soc_field)
            oamc_pkg::SOC_GND: mode_next = oamc_pkg::OAMC_MODE_GND;
            oamc_pkg::SOC_VDD: mode_next = oamc_pkg::OAMC_MODE_VDD;
            default: begin
               // reserved code 11 is treated like 00: unity gain if unity gain select is set, else basic operation
               mode_next = unity_gain_select ? oamc_pkg::OAMC_MODE_UNITY
                                             : oamc_pkg::OAMC_MODE_BASIC;
            end
         endcase
      end
   end

   // one register after the synchroniser keeps the mode glitch free
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_reg <= oamc_pkg::OAMC_MODE_BASIC;
      end else begin
         mode_reg <= mode_next;
      end
   end

   assign unity = (mode_reg == oamc_pkg::OAMC_MODE_UNITY);

   // ======================================================================================
   // input routing
   always_comb begin
      nr_next = chan_route(noninv_channel_select);
      ir_next = chan_route(inv_channel_select);
      if (inv_channel_select == oamc_pkg::CH_RAIL) begin
         ir_next = oamc_pkg::SRC_NONE;
      end
      if (inv_channel_select == oamc_pkg::CH_HALF) begin
         ir_next = oamc_pkg::SRC_NONE;
      end
      if (!ladder_enable && nr_next == oamc_pkg::SRC_LADDER) begin
         nr_next = oamc_pkg::SRC_NONE;
      end
      if (!ladder_enable && ir_next == oamc_pkg::SRC_LADDER) begin
         ir_next = oamc_pkg::SRC_NONE;
      end
      if (unity) begin
         ir_next = oamc_pkg::SRC_OUT;
      end
      if (adc_mode) begin
         nr_next = oamc_pkg::SRC_PIN;
      end
   end

   // ======================================================================================
   // switch routing, registered so the analog switches see one clean change per write
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         noninv_route   <= oamc_pkg::SRC_NONE;
         inv_route      <= oamc_pkg::SRC_NONE;
         amp_noninv_pin <= 2'h0;
         amp_inv_pin    <= 2'h0;
      end else begin
         noninv_route   <= nr_next;
         inv_route      <= ir_next;
         // adc channel wins over positive pin select in adc mode
         amp_noninv_pin <= adc_mode ? adc_positive_channel_select
                                    : positive_pin_select;
         // the ground code of the negative pin select has no pin of its own
         amp_inv_pin    <= negative_pin_select[1:0];
      end
   end

   // gain ladder; gain select means nothing while the ladder is off
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ladder_on   <= 1'b0;
         ladder_gain <= 3'h0;
      end else begin
         ladder_on   <= ladder_enable;
         ladder_gain <= gain_select;
      end
   end

   // amplifier enables and operating mode
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         amp_mode       <= 2'h0;
         amp_enable     <= 1'b0;
         charge_pump_on <= 1'b0;
      end else begin
         amp_mode       <= mode_reg;
         amp_enable     <= con0_reg[oamc_pkg::CON0_EN];
         charge_pump_on <= con0_reg[oamc_pkg::CON0_CPON];
      end
   end

   // converter connection
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         adc_from_amp   <= 1'b0;
         adc_noninv_pin <= 2'h0;
      end else begin
         adc_from_amp   <= adc_mode;
         adc_noninv_pin <= adc_positive_channel_select;
      end
   end

   // trim copy toward the analog trim; reset brings back the factory value at once
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         offset_trim <= FACTORY_TRIM;
      end else begin
         offset_trim <= trim_reg;
      end
   end

   // ======================================================================================
   // pin drivers
   always_comb begin
      amp_output_pin_o  = port_out_drive;
      amp_output_pin_oe = port_out_oe & ~con0_reg[oamc_pkg::CON0_EN];
      amp_inv_pin_o     = port_inv_drive;
      amp_inv_pin_oe    = port_inv_oe;
      if (con0_reg[oamc_pkg::CON0_EN] && !unity &&
          inv_channel_select == oamc_pkg::CH_PIN) begin
         amp_inv_pin_oe = 1'b0;
      end
   end
endmodule

// ===== logic/oamc_pkg.sv
// oamc_pkg: register map, field layout and encodings for the amplifier control
// ==========================================================================================
// How it works
// - amplifier enable forces the output pin port driver to high impedance
// - with override off, the mode comes from the software output control field
// - unity gain, override off, ties output to inverting input and frees that pin
// - noninverting channel picks the source; positive pin select only for the external pin
// - inverting channel picks the source; negative pin select only for the external pin
// - the gain ladder is used only while ladder enable is set; gain select sets gain
// - ladder code on a channel routes the ladder to that amplifier input
// - override enable hands mode control to the selected internal signal
// - normal polarity: high config while the signal is high, low config while low
// - polarity one inverts the signal before choosing the high or low config
// - override modes: basic, unity gain, rail drive to supply or ground
// - every reset reloads the factory trim into the offset trim register
// - in ADC mode the amplifier output feeds the ADC; ADC channel picks the pin
// - output control: 00 basic, 01 ground, 10 supply, 11 reserved
// - noninverting codes: ground, ladder, pin, half supply, first DAC, second DAC
package oamc_pkg;
   // ======================================================================================
   // register offsets
   localparam logic [3:0] ADDR_CON0  = 4'h0;
   localparam logic [3:0] ADDR_CON1  = 4'h1;
   localparam logic [3:0] ADDR_CON2  = 4'h2;
   localparam logic [3:0] ADDR_CON3  = 4'h3;
   localparam logic [3:0] ADDR_HWC   = 4'h4;
   localparam logic [3:0] ADDR_OSRC  = 4'h5;
   localparam logic [3:0] ADDR_TRIM  = 4'h6;
   localparam logic [3:0] ADDR_ADC   = 4'h7;
   localparam logic [3:0] ADDR_STAT  = 4'h8;
   // ======================================================================================
   // field positions
   localparam int CON0_EN    = 7;
   localparam int CON0_CPON  = 5;
   localparam int CON0_UNITY = 3;
   localparam int CON1_LADEN = 3;
   localparam int HWC_OVREN  = 7;
   localparam int HWC_OVPOL  = 3;
   localparam int ADC_OPAMD  = 7;
   // ======================================================================================
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] FACTORY_TRIM_DEFAULT = 8'h80;
   // ======================================================================================
   // encodings
   localparam logic [1:0] SOC_BASIC = 2'h0;
   localparam logic [1:0] SOC_GND   = 2'h1;
   localparam logic [1:0] SOC_VDD   = 2'h2;
   localparam logic [2:0] CH_RAIL   = 3'h0;
   localparam logic [2:0] CH_LADDER = 3'h1;
   localparam logic [2:0] CH_PIN    = 3'h2;
   localparam logic [2:0] CH_HALF   = 3'h3;
   localparam logic [2:0] CH_DAC1   = 3'h4;
   localparam logic [2:0] CH_DAC2   = 3'h5;
   localparam logic [2:0] NEG_VSS   = 3'h7;
   // override configuration codes: 000 basic, 001 unity gain, 010 ground, 011 supply
   localparam logic [2:0] HW_BASIC  = 3'h0;
   localparam logic [2:0] HW_UNITY  = 3'h1;
   localparam logic [2:0] HW_GND    = 3'h2;
   localparam logic [2:0] HW_VDD    = 3'h3;
   // route codes toward the analog switches
   localparam logic [2:0] SRC_NONE  = 3'h0;
   localparam logic [2:0] SRC_RAIL  = 3'h1;
   localparam logic [2:0] SRC_LADDER = 3'h2;
   localparam logic [2:0] SRC_PIN   = 3'h3;
   localparam logic [2:0] SRC_HALF  = 3'h4;
   localparam logic [2:0] SRC_DAC1  = 3'h5;
   localparam logic [2:0] SRC_DAC2  = 3'h6;
   localparam logic [2:0] SRC_OUT   = 3'h7;
   typedef enum logic [1:0] {
      OAMC_MODE_BASIC = 2'b00,
      OAMC_MODE_UNITY = 2'b01,
      OAMC_MODE_VDD   = 2'b11,
      OAMC_MODE_GND   = 2'b10
   } oamc_mode_e;
endpackage

// ===== logic/oamc_ovr_sync.sv
// oamc_ovr_sync: override source selection, two-flop synchroniser and polarity
`timescale 1ns/1ps
module oamc_ovr_sync #(
   parameter int N_SRC = 16
) (
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   input  wire logic [N_SRC-1:0]         src_in,
   input  wire logic [$clog2(N_SRC)-1:0] src_sel,
   input  wire logic                     polarity,
   output logic                          ovr_level
);
   logic meta_reg;
   logic sync_reg;
   logic pick;

   assign pick = src_in[src_sel];

   // ======================================================================================
   // synchroniser; first stage is only read by the second
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= pick;
         sync_reg <= meta_reg;
      end
   end

   assign ovr_level = sync_reg ^ polarity;
endmodule

// ===== tb/oamc_top_asserts.sv
// oamc_top_asserts: port-level checker for the amplifier control
`timescale 1ns/1ps
module oamc_top_chk #(
   parameter int         N_SRC        = 16,
   parameter logic [7:0] FACTORY_TRIM = oamc_pkg::FACTORY_TRIM_DEFAULT
) (
   input wire logic             mclk,
   input wire logic             sys_rst,
   input wire logic             reg_wr,
   input wire logic [N_SRC-1:0] ovr_src,
   input wire logic             port_out_drive,
   input wire logic             port_inv_oe,
   input wire logic             amp_output_pin_o,
   input wire logic             amp_output_pin_oe,
   input wire logic             amp_inv_pin_oe,
   input wire logic             amp_enable,
   input wire logic [1:0]       amp_mode,
   input wire logic [2:0]       noninv_route,
   input wire logic [1:0]       amp_noninv_pin,
   input wire logic [2:0]       inv_route,
   input wire logic             ladder_on,
   input wire logic [7:0]       offset_trim,
   input wire logic             adc_from_amp,
   input wire logic [1:0]       adc_noninv_pin
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ====
   // amp_enable lags the enable bit by one cycle, hence the look back
   chk_pin_tristate: assert property (amp_enable |-> !$past(amp_output_pin_oe))
      else $error("output pin driven while amplifier enabled");
   chk_pin_follow: assert property (amp_output_pin_o == port_out_drive)
      else $error("output pin data not taken from port");
   chk_inv_pin_oe: assert property (amp_inv_pin_oe |-> port_inv_oe)
      else $error("inverting pin driven without port enable");
   chk_unity_route: assert property (amp_mode == 2'h1 |-> inv_route == 3'h7)
      else $error("unity gain without output feedback");
   chk_unity_free: assert property (amp_mode == 2'h1 |->
      $past(amp_inv_pin_oe) == $past(port_inv_oe))
      else $error("inverting pin not released in unity gain");
   chk_ladder_gate: assert property (!ladder_on |->
      noninv_route != 3'h2 && inv_route != 3'h2)
      else $error("ladder routed while disabled");
   chk_adc_route: assert property (adc_from_amp |->
      noninv_route == 3'h3 && amp_noninv_pin == adc_noninv_pin)
      else $error("adc mode pin routing wrong");
   // six quiet cycles cover the write path and the override synchroniser
   chk_mode_quiet: assert property ((!reg_wr && $stable(ovr_src)) [*6] |=>
      $stable(amp_mode))
      else $error("mode changed without cause");
   chk_trim_reset: assert property ($past(sys_rst) |-> offset_trim == FACTORY_TRIM)
      else $error("trim not reloaded by reset");
endmodule

bind oamc_top oamc_top_chk #(.N_SRC(N_SRC), .FACTORY_TRIM(FACTORY_TRIM)) u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .ovr_src(ovr_src),
   .port_out_drive(port_out_drive), .port_inv_oe(port_inv_oe),
   .amp_output_pin_o(amp_output_pin_o), .amp_output_pin_oe(amp_output_pin_oe),
   .amp_inv_pin_oe(amp_inv_pin_oe), .amp_enable(amp_enable), .amp_mode(amp_mode),
   .noninv_route(noninv_route), .amp_noninv_pin(amp_noninv_pin), .inv_route(inv_route),
   .ladder_on(ladder_on), .offset_trim(offset_trim), .adc_from_amp(adc_from_amp),
   .adc_noninv_pin(adc_noninv_pin));

// ===== tb/oamc_src_model.sv
// oamc_src_model: override signal sources beside the amplifier
`timescale 1ns/1ps
module oamc_src_model #(
   parameter int N_SRC = 16
) (
   input  wire logic             mclk,
   input  wire logic [N_SRC-1:0] want,
   output logic      [N_SRC-1:0] ovr_src
);
   // sources live on other timing, so edges land mid-cycle to stress the synchroniser
   always @(posedge mclk) ovr_src <= #1.3 want;
endmodule

// ===== tb/tb_oamc_top.sv
// tb_oamc_top: random and corner-case bench for the amplifier control
`timescale 1ns/1ps
module tb_oamc_top;
   localparam logic [7:0] TRIM_F = 8'h5A;
   localparam logic [7:0] MSK [0:7] = '{8'hAB, 8'h7F, 8'h77, 8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h83};
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] src_want = 16'h0000;
   logic        p_od = 1'b0, p_oo = 1'b0, p_id = 1'b0, p_io = 1'b0;
   logic [15:0] ovr_src;
   logic [7:0]  rdata, trim_o, q;
   logic        o_pin, o_oe, i_pin, i_oe, en_o, cp_o, lad_o, adc_o;
   logic [1:0]  mode_o, np_o, ip_o, ap_o;
   logic [2:0]  nr_o, ir_o, lg_o;
   logic [7:0]  sh [0:7];
   logic [31:0] rnd = 32'h00011C59;
   int          n_fail = 0;
   int          total_checks = 0;

   always #2.5 mclk = ~mclk;

   oamc_top #(.N_SRC(16), .FACTORY_TRIM(TRIM_F)) uut (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .ovr_src(ovr_src),
      .port_out_drive(p_od), .port_out_oe(p_oo), .amp_output_pin_o(o_pin),
      .amp_output_pin_oe(o_oe), .port_inv_drive(p_id), .port_inv_oe(p_io),
      .amp_inv_pin_o(i_pin), .amp_inv_pin_oe(i_oe), .amp_enable(en_o),
      .charge_pump_on(cp_o), .amp_mode(mode_o), .noninv_route(nr_o),
      .amp_noninv_pin(np_o), .inv_route(ir_o), .amp_inv_pin(ip_o), .ladder_on(lad_o),
      .ladder_gain(lg_o), .offset_trim(trim_o), .adc_from_amp(adc_o),
      .adc_noninv_pin(ap_o));
   oamc_src_model #(.N_SRC(16)) u_src (.mclk(mclk), .want(src_want), .ovr_src(ovr_src));

   // ====
   // helpers
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic lvl();
      return src_want[sh[5][3:0]] ^ sh[4][3];
   endfunction
   // software modes are mapped onto the override code space: 1 unity, 2 ground, 3 supply
   function automatic logic [1:0] f_mode();
      logic [2:0] c;
      if (sh[4][7])
         c = lvl() ? sh[4][6:4] : sh[4][2:0];
      else
         c = (sh[0][1:0] == 2'h1) ? 3'h2 : (sh[0][1:0] == 2'h2) ? 3'h3 : {2'h0, sh[0][3]};
      case (c)
         3'h1: return 2'h1;
         3'h2: return 2'h2;
         3'h3: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction
   function automatic logic [2:0] f_nr(logic [2:0] ch, logic adc);
      if (adc)
         return 3'h3;
      case (ch)
         3'h0: return 3'h1;
         3'h1: return sh[1][3] ? 3'h2 : 3'h0;
         3'h2: return 3'h3;
         3'h3: return 3'h4;
         3'h4: return 3'h5;
         3'h5: return 3'h6;
         default: return 3'h0;
      endcase
   endfunction
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      if (a < 4'h8)
         sh[a[2:0]] = d & MSK[a[2:0]];
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 q = rdata;
   endtask
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         sh[i] = 8'h00;
      sh[6] = TRIM_F;
   endtask
   task automatic check_outs();
      logic [1:0] m;
      logic [2:0] n, r;
      repeat (8) @(posedge mclk);
      #1 m = f_mode();
      n = sh[2][6:4];
      r = f_nr(sh[2][2:0], sh[7][7]);
      chk(mode_o, m);
      chk({en_o, cp_o, lad_o, adc_o}, {sh[0][7], sh[0][5], sh[1][3], sh[7][7]});
      chk({o_oe, o_pin, i_pin}, {p_oo & ~sh[0][7], p_od, p_id});
      chk(i_oe, p_io & ~(sh[0][7] & (m != 2'h1) & (n == 3'h2)));
      chk(nr_o, r);
      chk(ir_o, m == 2'h1 ? 3'h7 : (n == 3'h0 || n == 3'h3) ? 3'h0 : f_nr(n, 1'b0));
      if (r == 3'h3)
         chk(np_o, sh[7][7] ? sh[7][1:0] : sh[3][1:0]);
      if (m != 2'h1 && n == 3'h2 && !sh[1][2])
         chk(ip_o, sh[1][1:0]);
      if (sh[1][3])
         chk(lg_o, sh[1][6:4]);
      chk(trim_o, sh[6]);
      chk(ap_o, sh[7][1:0]);
      rd(4'h8);
      chk(q[2], lvl());
      chk(q[1:0], m);
   endtask
   task automatic readback();
      for (int a = 0; a < 16; a++) begin
         rd(a[3:0]);
         if (a != 8)
            chk(q, a < 8 ? sh[a[2:0]] : 8'h00);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ====
   // sequence
   initial begin
      do_reset();
      readback();
      for (int i = 0; i < 8; i++) begin
         wr(4'h0, {1'b1, 3'h0, i[2], 1'b0, i[1:0]});
         wr(4'h1, {1'b0, i[2:0], i[0], 3'h0});
         wr(4'h2, {1'b0, i[2:0], 1'b0, i[2:0]});
         check_outs();
      end
      for (int i = 0; i < 16; i++) begin
         wr(4'h4, {1'b1, i[2:0], i[3], ~i[2:0]});
         wr(4'h5, i[7:0]);
         src_want <= 16'hA5C3 ^ {16{i[0]}};
         check_outs();
      end
      for (int k = 0; k < 40; k++) begin
         for (int a = 0; a < 8; a++) begin
            rnd = lfsr(rnd);
            wr(a[3:0], rnd[7:0]);
         end
         rnd = lfsr(rnd);
         src_want <= rnd[15:0];
         {p_od, p_oo, p_id, p_io} <= rnd[19:16];
         check_outs();
         readback();
      end
      wr(4'h8, 8'hFF);
      wr(4'hF, 8'hFF);
      readback();
      // offset recalibration: half-supply reference, unity gain, then a trim
      wr(4'h4, 8'h00);
      wr(4'h2, 8'h03);
      wr(4'h0, 8'h88);
      wr(4'h6, 8'h3C);
      check_outs();
      do_reset();
      check_outs();
      readback();
      stop_test();
   end
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end
endmodule
